// ==== include/irq_pin_vector_consts.svh ====
// Constants for the pin interrupt detector and vector priority logic.
// Assumes a single system clock; all control bits arrive as plain ports.
//
// Functional notes
// - Pin counts as interrupt input only while the function enable is one.
// - Software polarity selects which edge or level direction counts as asserted.
// - Mode select chooses edges only or edges plus sustained asserted level.
// - Events set pending except edges in stop mode; CPU request only with the request enable set.
// - Rising-edge configuration turns the pull device into a pulldown.
// - Current pin level is offered to branch-on-level instructions while enabled.
// - With clocks running, detection is synchronous to the system clock.
// - In stop mode an asynchronous path lets an enabled pin event wake; here stop_wake is the asserted pin level registered on sys_clk.
// - Deasserted to asserted transition sets the pending flag.
// - Edge-plus-level mode holds pending set while pin stays asserted.
// - Every source sets its flag; request forwarded only with local enable.
// - Mask clear: finish instruction, stack five registers, set mask, fetch vector.
// - Vector is two bytes: high address byte first, low byte next higher.
// - Highest priority pending source wins; lower vector number is higher.
// - Vectors descend by two; reset FFFE, pin FFFA, lowest assigned FFD2.
// - Vectors 23 to 31, FFD0 down to FFC0, have no hardware source.
// - Reset vector shared by watchdog, clock loss, low voltage, power-on, pin, opcode.
// - Polarity one means rising or high; zero means falling or low.
// - Pull-disable one turns the pull device off while the pin is enabled.
`ifndef IRQ_PIN_VECTOR_CONSTS_SVH
`define IRQ_PIN_VECTOR_CONSTS_SVH
`define VEC_TOP_ADDR 16'hFFFE
`define VEC_RESET_NUM 5'h00
`define VEC_SWI_NUM 5'h01
`define VEC_PIN_NUM 5'h02
`define VEC_LAST_HW_NUM 5'h16
`define VEC_SRC_COUNT 23
`define STACK_BYTES 3'h5
`endif

// ==== include/irq_pin_vector_pkg.sv ====
// Types for the pin interrupt detector and vector priority logic.
// Assumes the constants header is compiled alongside.
package irq_pin_vector_pkg;
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_STACK = 3'b001,
      ST_VEC_HI = 3'b010,
      ST_VEC_LO = 3'b011,
      ST_DONE = 3'b100
   } entry_e;
   typedef logic [4:0] vec_num_t;
endpackage

// ==== hw/irq_pin_vector_priority.sv ====
// Pin interrupt detector, priority encoder and CPU entry sequencer.
// Assumes sources hold their flags until served and the CPU steps entry_next.
`timescale 1ns/1ps
`default_nettype none
`include "irq_pin_vector_consts.svh"
module irq_pin_vector_priority #(
   parameter int NSRC = `VEC_SRC_COUNT
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Pin and pin controls
   input wire logic pin_in,
   input wire logic pin_int_function_enable,
   input wire logic pin_polarity_select,
   input wire logic edge_level_mode_select,
   input wire logic pin_int_request_enable,
   input wire logic pin_pull_disable,
   input wire logic pin_ack,
   input wire logic stop_mode,
   // Other sources, bit n is vector n (bits 0..2 unused here; reset comes from reset_cause_any)
   input wire logic [NSRC-1:0] src_flag,
   input wire logic [NSRC-1:0] src_enable,
   input wire logic reset_cause_any,
   // CPU side
   input wire logic global_mask,
   input wire logic instr_boundary,
   input wire logic entry_next,
   // Outputs
   output logic pin_event_pending_flag,
   output logic pin_level_for_branch,
   output logic pull_enable,
   output logic pull_is_down,
   output logic stop_wake,
   output logic cpu_int_request,
   output logic entry_active,
   output logic [2:0] stack_index,
   output logic set_mask,
   output logic [15:0] fetch_addr,
   output irq_pin_vector_pkg::vec_num_t served_vector
);
   import irq_pin_vector_pkg::*;
   // Source count must leave room for reset, software and pin vectors
   if (NSRC < 3 || NSRC > `VEC_SRC_COUNT) begin : g_nsrc_bad
      $error("NSRC out of range");
   end
   // Bits 0..2 are reset, software and pin: never taken from src_flag
   localparam logic [NSRC-1:0] HW_SRC_MASK = ~(NSRC'(3'h7));
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [2:0] sync;
      logic last;
      logic pend;
      logic lvl;
      logic pull_en;
      logic pull_dn;
      logic wake;
      logic req;
      entry_e st;
      logic act;
      logic [2:0] idx;
      logic setm;
      logic [15:0] addr;
      vec_num_t vec;
   } state_s;
   state_s s_q, s_d;
   function automatic logic [15:0] vec_addr(input vec_num_t n);
      // Vector n high byte lives two bytes below n-1
      vec_addr = `VEC_TOP_ADDR - {10'h000, n, 1'b0};
   endfunction
   function automatic vec_num_t pick(input logic [NSRC-1:0] r);
      pick = 5'h1F;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (r[i]) pick = vec_num_t'(i);
      end
   endfunction
   // ****************************************************************
   // Pin detector, request forwarding and entry sequencer
   // ****************************************************************
   logic asserted, rise, pin_stop_async;
   logic [NSRC-1:0] reqs;
   assign pin_stop_async = stop_mode && pin_int_function_enable &&
      ((pin_in ~^ pin_polarity_select));
   always_comb begin
      s_d = s_q;
      // Synchroniser chain; stages 2 and 3 must agree
      s_d.sync = {s_q.sync[1:0], pin_in};
      if (s_q.sync[2] == s_q.sync[1]) s_d.last = s_q.sync[2];
      asserted = (s_d.last == pin_polarity_select);
      rise = asserted && (s_q.last != pin_polarity_select);
      // Acknowledge clears, but loses to an event
      if (pin_ack) s_d.pend = 1'b0;
      if (pin_int_function_enable && !stop_mode && rise) s_d.pend = 1'b1;
      if (pin_int_function_enable && edge_level_mode_select && asserted) s_d.pend = 1'b1;
      s_d.lvl = pin_int_function_enable ? s_q.last : 1'b1;
      s_d.pull_en = pin_int_function_enable && !pin_pull_disable;
      s_d.pull_dn = pin_int_function_enable && pin_polarity_select;
      s_d.wake = pin_stop_async;
      // Flags forward only with local enable
      reqs = src_flag & src_enable;
      reqs[`VEC_PIN_NUM] = s_q.pend && pin_int_request_enable;
      reqs[`VEC_RESET_NUM] = reset_cause_any;
      // Software interrupt is an instruction, not a request line
      reqs[`VEC_SWI_NUM] = 1'b0;
      s_d.req = |reqs[NSRC-1:1];
      s_d.setm = 1'b0;
      case (s_q.st)
         ST_RUN: begin
            if (s_q.req && !global_mask && instr_boundary) begin
               s_d.st = ST_STACK;
               s_d.idx = 3'h0;
            end
         end
         ST_STACK: begin
            if (entry_next) begin
               if (s_q.idx == `STACK_BYTES - 3'h1) begin
                  s_d.st = ST_VEC_HI;
                  s_d.setm = 1'b1;
                  s_d.vec = pick(reqs);
                  s_d.addr = vec_addr(pick(reqs));
               end else begin
                  s_d.idx = s_q.idx + 3'h1;
               end
            end
         end
         ST_VEC_HI: begin
            if (entry_next) begin
               s_d.st = ST_VEC_LO;
               s_d.addr = s_q.addr + 16'h0001;
            end
         end
         ST_VEC_LO: begin
            if (entry_next) s_d.st = ST_DONE;
         end
         default: s_d.st = ST_RUN;
      endcase
      if (reset_cause_any) begin
         s_d.st = ST_VEC_HI;
         s_d.vec = `VEC_RESET_NUM;
         s_d.addr = vec_addr(`VEC_RESET_NUM);
      end
      // Busy flag registered so the output comes from a flop
      s_d.act = (s_d.st != ST_RUN);
   end
   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         // Idle pin is pulled high; start there to avoid a false edge
         s_q <= '{sync: 3'h7, last: 1'b1, pend: 1'b0, lvl: 1'b1, pull_en: 1'b0,
            pull_dn: 1'b0, wake: 1'b0, req: 1'b0, st: ST_RUN, act: 1'b0, idx: 3'h0,
            setm: 1'b0, addr: 16'hFFFE, vec: 5'h00};
      end else begin
         s_q <= s_d;
      end
   end
   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign pin_event_pending_flag = s_q.pend;
   assign pin_level_for_branch = s_q.lvl;
   assign pull_enable = s_q.pull_en;
   assign pull_is_down = s_q.pull_dn;
   assign stop_wake = s_q.wake;
   assign cpu_int_request = s_q.req;
   assign entry_active = s_q.act;
   assign stack_index = s_q.idx;
   assign set_mask = s_q.setm;
   assign fetch_addr = s_q.addr;
   assign served_vector = s_q.vec;
   // ****************************************************************
   // Checks
   // ****************************************************************
   pend_no_req_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.pend && !pin_int_request_enable && !(|(src_flag & src_enable & HW_SRC_MASK))
       && !reset_cause_any) |=> !s_q.req) else $error("request without enable");
   level_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      (pin_int_function_enable && edge_level_mode_select && s_d.last == pin_polarity_select)
      |=> s_q.pend) else $error("level did not hold flag");
   pull_dir_a: assert property (@(posedge sys_clk) disable iff (reset)
      (pin_int_function_enable && pin_polarity_select) |=> pull_is_down)
      else $error("pull not down");
   pull_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      pin_pull_disable |=> !pull_enable) else $error("pull not disabled");
   disabled_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
      (!pin_int_function_enable && !s_q.pend) |=> !s_q.pend) else $error("disabled pin set flag");
   lo_after_hi_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.st == ST_VEC_HI && entry_next && !reset_cause_any) |=>
      fetch_addr == $past(fetch_addr) + 16'h0001) else $error("low byte address wrong");
   mask_set_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.st == ST_STACK && entry_next && s_q.idx == 3'h4 && !reset_cause_any)
      |=> set_mask && fetch_addr[0] == 1'b0) else $error("mask not set at fetch");
   reset_vec_a: assert property (@(posedge sys_clk) disable iff (reset)
      reset_cause_any |=> fetch_addr == 16'hFFFE) else $error("reset vector wrong");
   wake_a: assert property (@(posedge sys_clk) disable iff (reset)
      (stop_mode && pin_int_function_enable && pin_in == pin_polarity_select)
      |=> stop_wake) else $error("no stop wake");
   // ****************************************************************
   // Detector checks
   // ****************************************************************
   edge_sets_a: assert property (@(posedge sys_clk) disable iff (reset)
      (pin_int_function_enable && !stop_mode && rise) |=> s_q.pend)
      else $error("edge did not set flag");
   ack_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
      (pin_ack && !edge_level_mode_select && !(pin_int_function_enable && !stop_mode && rise))
      |=> !s_q.pend) else $error("acknowledge did not clear");
   ack_loses_a: assert property (@(posedge sys_clk) disable iff (reset)
      (pin_ack && pin_int_function_enable && !stop_mode && rise) |=> s_q.pend)
      else $error("acknowledge beat an event");
   stop_blocks_a: assert property (@(posedge sys_clk) disable iff (reset)
      (stop_mode && !edge_level_mode_select && !s_q.pend) |=> !s_q.pend)
      else $error("flag set in stop");
   sync_agree_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.sync[2] != s_q.sync[1]) |=> $stable(s_q.last))
      else $error("level moved without agreement");
   sync_take_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.sync[2] == s_q.sync[1]) |=> s_q.last == $past(s_q.sync[2]))
      else $error("agreed level not taken");
   deassert_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
      (pin_int_function_enable && !edge_level_mode_select && !s_q.pend && !rise
       && s_q.last == pin_polarity_select) |=> !s_q.pend) else $error("wrong edge set flag");
   level_branch_a: assert property (@(posedge sys_clk) disable iff (reset)
      pin_int_function_enable |=> pin_level_for_branch == $past(s_q.last))
      else $error("branch level wrong");
   branch_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      !pin_int_function_enable |=> pin_level_for_branch)
      else $error("branch level not idle");
   pull_on_a: assert property (@(posedge sys_clk) disable iff (reset)
      (pin_int_function_enable && !pin_pull_disable) |=> pull_enable)
      else $error("pull not enabled");
   pull_up_a: assert property (@(posedge sys_clk) disable iff (reset)
      !pin_polarity_select |=> !pull_is_down) else $error("pull not up");
   pull_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      !pin_int_function_enable |=> (!pull_enable && !pull_is_down))
      else $error("pull active while disabled");
   wake_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      !stop_mode |=> !stop_wake) else $error("wake outside stop");
   wake_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
      (stop_mode && pin_in != pin_polarity_select) |=> !stop_wake)
      else $error("wake on deasserted pin");
   // ****************************************************************
   // Priority and entry checks
   // ****************************************************************
   req_fwd_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.pend && pin_int_request_enable) |=> cpu_int_request)
      else $error("pin request not forwarded");
   src_fwd_a: assert property (@(posedge sys_clk) disable iff (reset)
      (src_flag[NSRC-1] && src_enable[NSRC-1]) |=> cpu_int_request)
      else $error("source request not forwarded");
   src_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
      (!(|(src_flag & src_enable & HW_SRC_MASK)) && !(s_q.pend && pin_int_request_enable))
      |=> !cpu_int_request) else $error("request without source");
   entry_start_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.st == ST_RUN && s_q.req && !global_mask && instr_boundary && !reset_cause_any)
      |=> (entry_active && stack_index == 3'h0)) else $error("entry did not start");
   masked_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.st == ST_RUN && global_mask && !reset_cause_any) |=> !entry_active)
      else $error("entry while masked");
   stack_step_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.st == ST_STACK && entry_next && s_q.idx != 3'h4 && !reset_cause_any)
      |=> stack_index == $past(stack_index) + 3'h1) else $error("stack step wrong");
   stack_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.st == ST_STACK && !entry_next && !reset_cause_any)
      |=> ($stable(stack_index) && entry_active)) else $error("stack moved without step");
   setm_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
      set_mask |=> !set_mask) else $error("mask pulse too long");
   pin_first_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.st == ST_STACK && entry_next && s_q.idx == 3'h4 && !reset_cause_any
       && s_q.pend && pin_int_request_enable) |=> served_vector == `VEC_PIN_NUM)
      else $error("pin not highest pending");
   hi_even_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.st == ST_VEC_HI) |-> fetch_addr[0] == 1'b0) else $error("high byte address odd");
   lo_odd_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.st == ST_VEC_LO) |-> fetch_addr[0] == 1'b1) else $error("low byte address even");
   addr_map_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.st == ST_VEC_HI) |-> fetch_addr == 16'hFFFE - {10'h000, served_vector, 1'b0})
      else $error("vector address map wrong");
   vec_free_a: assert property (@(posedge sys_clk) disable iff (reset)
      (s_q.st == ST_VEC_HI) |-> (served_vector < 5'h17 || served_vector == 5'h1F))
      else $error("free vector served");
   reset_num_a: assert property (@(posedge sys_clk) disable iff (reset)
      reset_cause_any |=> served_vector == 5'h00) else $error("reset vector number wrong");
endmodule
`default_nettype wire

// ==== tb/cpu_step_model.sv ====
// CPU core model that steps the interrupt entry sequence.
// Assumes the design's entry_active output and one shared clock.
`timescale 1ns/1ps
`default_nettype none
module cpu_step_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Entry handshake
   input wire logic entry_active,
   output logic entry_next
);
   // Steps on alternate cycles; a slow core is the harder case
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         entry_next <= 1'b0;
      end else begin
         entry_next <= entry_active && !entry_next;
      end
   end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the pin detector, priority pick and entry walk.
// Assumes the CPU step model answers entry_active with entry_next pulses.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
   logic sys_clk, reset, pin_in, fn_en, pol, lvl, req_en, pull_dis, pin_ack, stop_mode;
   logic [22:0] src_flag, src_enable;
   logic rst_cause, global_mask, instr_boundary, entry_next, pending, level, pull_en, pull_dn;
   logic stop_wake, cpu_req, entry_active, set_mask;
   logic [2:0] stack_index;
   logic [15:0] fetch_addr;
   logic [4:0] served_vector;
   int fails = 0;
   int tests_run = 0;
   irq_pin_vector_priority dut (.sys_clk(sys_clk), .reset(reset), .pin_in(pin_in),
      .pin_int_function_enable(fn_en), .pin_polarity_select(pol),
      .edge_level_mode_select(lvl), .pin_int_request_enable(req_en),
      .pin_pull_disable(pull_dis), .pin_ack(pin_ack), .stop_mode(stop_mode),
      .src_flag(src_flag), .src_enable(src_enable), .reset_cause_any(rst_cause),
      .global_mask(global_mask), .instr_boundary(instr_boundary), .entry_next(entry_next),
      .pin_event_pending_flag(pending), .pin_level_for_branch(level), .pull_enable(pull_en),
      .pull_is_down(pull_dn), .stop_wake(stop_wake), .cpu_int_request(cpu_req),
      .entry_active(entry_active), .stack_index(stack_index), .set_mask(set_mask),
      .fetch_addr(fetch_addr), .served_vector(served_vector));
   cpu_step_model cpu (.sys_clk(sys_clk), .reset(reset), .entry_active(entry_active),
      .entry_next(entry_next));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic ack();
      pin_ack = 1'b1;
      tick(1);
      pin_ack = 1'b0;
      tick(2);
   endtask
   task automatic wait_next();
      for (int j = 0; j < 8 && entry_next !== 1'b1; j++) tick(1);
   endtask
   // ****************************
   // Entry walk for one vector
   // ****************************
   task automatic serve(input logic [4:0] n);
      instr_boundary = 1'b1;
      tick(1);
      instr_boundary = 1'b0;
      for (int k = 0; k < 5; k++) begin
         wait_next();
         `CHK(stack_index, 3'(k))
         tick(1);
      end
      `CHK(set_mask, 1'b1)
      `CHK(entry_active, 1'b1)
      `CHK(served_vector, n)
      `CHK(fetch_addr, 16'hFFFE - {10'h000, n, 1'b0})
      wait_next();
      tick(1);
      `CHK(fetch_addr, 16'hFFFF - {10'h000, n, 1'b0})
      for (int j = 0; j < 8 && entry_active !== 1'b0; j++) tick(1);
      `CHK(entry_active, 1'b0)
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #40000;
      fails++;
      final_report();
   end
   initial begin
      {reset, pin_in, global_mask} = 3'h7;
      {fn_en, pol, lvl, req_en, pull_dis, pin_ack, stop_mode, rst_cause} = 8'h00;
      {instr_boundary, src_flag, src_enable} = '0;
      tick(4);
      reset = 1'b0;
      `CHK(fetch_addr, 16'hFFFE)
      pin_in = 1'b0;
      tick(3);
      pin_in = 1'b1;
      tick(8);
      `CHK(pending, 1'b0)
      {fn_en, pol, pin_in} = 3'h6;
      tick(8);
      `CHK(pull_dn, 1'b1)
      `CHK(pull_en, 1'b1)
      pin_in = 1'b1;
      tick(8);
      `CHK(pending, 1'b1)
      `CHK(level, 1'b1)
      `CHK(cpu_req, 1'b0)
      ack();
      `CHK(pending, 1'b0)
      {pol, lvl, pull_dis} = 3'h3;
      pin_in = 1'b0;
      tick(8);
      `CHK(pending, 1'b1)
      `CHK(pull_en, 1'b0)
      ack();
      `CHK(pending, 1'b1)
      `CHK(level, 1'b0)
      pin_in = 1'b1;
      tick(8);
      ack();
      `CHK(pending, 1'b0)
      {req_en, global_mask, pin_in} = 3'h4;
      tick(8);
      `CHK(cpu_req, 1'b1)
      serve(5'h02);
      pin_in = 1'b1;
      tick(8);
      ack();
      src_flag[5] = 1'b1;
      tick(3);
      `CHK(cpu_req, 1'b0)
      src_enable = '1;
      for (int n = 3; n < 23; n++) begin
         src_flag = (23'h1 << n) | 23'h400000;
         tick(2);
         serve(5'(n));
         src_flag = '0;
         tick(2);
      end
      rst_cause = 1'b1;
      tick(1);
      rst_cause = 1'b0;
      `CHK(fetch_addr, 16'hFFFE)
      `CHK(served_vector, 5'h00)
      tick(12);
      {pol, lvl, stop_mode, pin_in} = 4'hA;
      tick(4);
      pin_in = 1'b1;
      tick(4);
      `CHK(stop_wake, 1'b1)
      `CHK(pending, 1'b0)
      stop_mode = 1'b0;
      pin_in = 1'b0;
      tick(8);
      pin_in = 1'b1;
      tick(3);
      pin_ack = 1'b1;
      tick(1);
      pin_ack = 1'b0;
      `CHK(pending, 1'b1)
      final_report();
   end
endmodule
`default_nettype wire
